// ---- core/lcd_vs_regs.sv ----
// LCD register bank: virtual screen, STN shade maps, dither, override, irqs.
// Assumes a one-cycle strobe register port and synchronous event inputs.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module lcd_vs_regs
  import lcd_vs_pkg::*;
#(
  parameter int DITHER_WIDTH = DITHER_W
)(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // Register port
  input  wire logic [31:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  // Events from the fetch engine
  input  wire logic        fifo_level_i,
  input  wire logic        fetch_step_i,
  // STN colour codes and frame data
  input  wire logic [2:0]  red_code_i,
  input  wire logic [2:0]  green_code_i,
  input  wire logic [1:0]  blue_code_i,
  input  wire logic [23:0] frame_data_i,
  // Video side
  output logic [3:0]       red_shade_o,
  output logic [3:0]       green_shade_o,
  output logic [3:0]       blue_shade_o,
  output logic [23:0]      video_data_o,
  output logic [31:0]      fetch_addr_o,
  output logic [DITHER_WIDTH-1:0] dither_o,
  output logic             video_output_enable_o,
  output logic             frame_sync_irq_o,
  output logic             irq_o
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [HW_FIELD_W-1:0]   line_skip_halfwords_q;
  logic [HW_FIELD_W-1:0]   view_width_halfwords_q;
  logic [31:0]             red_shade_select_q;
  logic [31:0]             green_shade_select_q;
  logic [BLUE_MAP_W-1:0]   blue_shade_select_q;
  logic [DITHER_WIDTH-1:0] dither_q;
  logic                    override_color_enable_q;
  logic [OVR_VAL_W-1:0]    override_color_value_q;
  logic                    override_live_q;
  logic [IRQ_W-1:0]        irq_pending_q;
  logic [IRQ_W-1:0]        irq_source_q;
  logic [IRQ_W-1:0]        irq_mask_q;
  logic [BANK_W-1:0]       buffer_bank_q;
  logic [BASE_W-1:0]       upper_base_addr_q;
  logic [BASE_W-1:0]       lower_base_addr_q;
  logic                    tft_mode_q;
  logic [IRQ_W-1:0]        events;
  logic                    frame_done;
  logic [31:0]             fetch_addr;
  logic [31:0]             rd_d;

  function automatic logic [3:0] nibble_pick(input logic [31:0] map, input logic [2:0] code);
    nibble_pick = map[{code, 2'b00} +: 4];
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  // ------------------------------------------------------------------
  // Configuration writes
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_skip_halfwords_q  <= '0;
      view_width_halfwords_q <= '0;
    end else if (reg_wr_i && hit(reg_addr_i, ADDR_VIRTUAL_SCREEN)) begin
      // Fields taken as written; host keeps output disabled meanwhile
      line_skip_halfwords_q  <= reg_wdata_i[SKIP_LSB +: HW_FIELD_W];
      view_width_halfwords_q <= reg_wdata_i[HW_FIELD_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      red_shade_select_q   <= RST_WORD;
      green_shade_select_q <= RST_WORD;
      blue_shade_select_q  <= '0;
      dither_q             <= '0;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, ADDR_RED_SHADE))
        red_shade_select_q <= reg_wdata_i;
      if (hit(reg_addr_i, ADDR_GREEN_SHADE))
        green_shade_select_q <= reg_wdata_i;
      if (hit(reg_addr_i, ADDR_BLUE_SHADE))
        blue_shade_select_q <= reg_wdata_i[BLUE_MAP_W-1:0];
      // Any value stored; only the two known patterns are meaningful
      if (hit(reg_addr_i, ADDR_DITHER))
        dither_q <= reg_wdata_i[DITHER_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      override_color_enable_q <= 1'b0;
      override_color_value_q  <= '0;
    end else if (reg_wr_i && hit(reg_addr_i, ADDR_OVERRIDE)) begin
      override_color_enable_q <= reg_wdata_i[OVR_EN_BIT];
      override_color_value_q  <= reg_wdata_i[OVR_VAL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      buffer_bank_q         <= '0;
      upper_base_addr_q     <= '0;
      lower_base_addr_q     <= '0;
      video_output_enable_o <= 1'b0;
      tft_mode_q            <= 1'b0;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, ADDR_FRAME_BASE)) begin
        buffer_bank_q     <= reg_wdata_i[BANK_LSB +: BANK_W];
        upper_base_addr_q <= reg_wdata_i[BASE_W-1:0];
      end
      if (hit(reg_addr_i, ADDR_FRAME_END))
        lower_base_addr_q <= reg_wdata_i[BASE_W-1:0];
      if (hit(reg_addr_i, ADDR_CTRL)) begin
        video_output_enable_o <= reg_wdata_i[CTRL_ENABLE];
        tft_mode_q            <= reg_wdata_i[CTRL_TFT];
      end
    end
  end

  // ------------------------------------------------------------------
  // Address walker
  // ------------------------------------------------------------------
  // Base address changes reach the walker only at its next restart, but bank_i
  // feeds addr_o directly, so a bank change takes effect mid-frame
  lcd_addr_counter u_addr (
    .clk_sys_i    (clk_sys_i),
    .nrst_i       (nrst_i),
    .run_i        (video_output_enable_o),
    .bank_i       (buffer_bank_q),
    .base_i       (upper_base_addr_q),
    .end_i        (lower_base_addr_q),
    .width_i      (view_width_halfwords_q),
    .skip_i       (line_skip_halfwords_q),
    .step_i       (fetch_step_i),
    .addr_o       (fetch_addr),
    .frame_done_o (frame_done)
  );

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      fetch_addr_o <= '0;
    else
      fetch_addr_o <= fetch_addr;
  end

  // ------------------------------------------------------------------
  // Video data path
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      red_shade_o   <= '0;
      green_shade_o <= '0;
      blue_shade_o  <= '0;
      dither_o      <= '0;
    end else begin
      red_shade_o   <= nibble_pick(red_shade_select_q, red_code_i);
      green_shade_o <= nibble_pick(green_shade_select_q, green_code_i);
      blue_shade_o  <= nibble_pick({16'h0000, blue_shade_select_q},
                                   {1'b0, blue_code_i});
      dither_o      <= dither_q;
    end
  end

  // Override latched at frame boundary so a frame is never half replaced
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      override_live_q <= 1'b0;
    else if (frame_done || !video_output_enable_o)
      override_live_q <= override_color_enable_q && tft_mode_q;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      video_data_o <= '0;
    else if (override_live_q)
      video_data_o <= override_color_value_q;
    else
      video_data_o <= frame_data_i;
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  assign events = {frame_done, fifo_level_i};

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      irq_source_q <= '0;
    else
      irq_source_q <= (irq_source_q
                       & ~((reg_wr_i && hit(reg_addr_i, ADDR_IRQ_SRC))
                           ? reg_wdata_i[IRQ_W-1:0] : 2'h0)
                       & ~((reg_rd_i && hit(reg_addr_i, ADDR_IRQ_SRC))
                           ? 2'h3 : 2'h0))
                      | events;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      irq_pending_q <= '0;
    else
      irq_pending_q <= (irq_pending_q
                        & ~((reg_wr_i && hit(reg_addr_i, ADDR_IRQ_PEND))
                            ? reg_wdata_i[IRQ_W-1:0] : 2'h0)
                        & ~((reg_rd_i && hit(reg_addr_i, ADDR_IRQ_PEND))
                            ? 2'h3 : 2'h0))
                       | (irq_source_q & ~irq_mask_q);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      irq_mask_q <= RST_MASK;
    else if (reg_wr_i && hit(reg_addr_i, ADDR_IRQ_MASK))
      irq_mask_q <= reg_wdata_i[IRQ_W-1:0];
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o            <= 1'b0;
      frame_sync_irq_o <= 1'b0;
    end else begin
      irq_o            <= |(irq_pending_q & ~irq_mask_q);
      frame_sync_irq_o <= irq_pending_q[IRQ_FRAME_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  // Unmapped addresses, the test range included, read as zero
  always_comb begin
    rd_d = RD_UNMAPPED;
    case (reg_addr_i)
      ADDR_VIRTUAL_SCREEN: rd_d = {10'h000, line_skip_halfwords_q, view_width_halfwords_q};
      ADDR_RED_SHADE:      rd_d = red_shade_select_q;
      ADDR_GREEN_SHADE:    rd_d = green_shade_select_q;
      ADDR_BLUE_SHADE:     rd_d = {16'h0000, blue_shade_select_q};
      ADDR_DITHER:         rd_d = 32'(dither_q);
      ADDR_OVERRIDE:       rd_d = {7'h00, override_color_enable_q, override_color_value_q};
      ADDR_IRQ_PEND:       rd_d = {30'h0, irq_pending_q};
      ADDR_IRQ_SRC:        rd_d = {30'h0, irq_source_q};
      ADDR_IRQ_MASK:       rd_d = {30'h0, irq_mask_q};
      ADDR_FRAME_BASE:     rd_d = {2'h0, buffer_bank_q, upper_base_addr_q};
      ADDR_FRAME_END:      rd_d = {11'h000, lower_base_addr_q};
      ADDR_CTRL:           rd_d = {30'h0, tft_mode_q, video_output_enable_o};
      ADDR_STATUS:         rd_d = {30'h0, override_live_q, |irq_pending_q};
      default:             rd_d = RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      reg_rdata_o <= '0;
    else if (reg_rd_i)
      reg_rdata_o <= rd_d;
    else
      reg_rdata_o <= '0;
  end

endmodule // lcd_vs_regs

// ---- core/lcd_vs_pkg.sv ----
// Constants for the LCD virtual screen, shade map and interrupt register bank.
// Assumes a plain register port with byte addresses and 32-bit data.
package lcd_vs_pkg;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [31:0] ADDR_VIRTUAL_SCREEN = 32'h4d00001c;
  localparam logic [31:0] ADDR_RED_SHADE      = 32'h4d000020;
  localparam logic [31:0] ADDR_GREEN_SHADE    = 32'h4d000024;
  localparam logic [31:0] ADDR_BLUE_SHADE     = 32'h4d000028;
  localparam logic [31:0] ADDR_DITHER         = 32'h4d00004c;
  localparam logic [31:0] ADDR_OVERRIDE       = 32'h4d000050;
  localparam logic [31:0] ADDR_IRQ_PEND       = 32'h4d000054;
  localparam logic [31:0] ADDR_IRQ_SRC        = 32'h4d000058;
  localparam logic [31:0] ADDR_IRQ_MASK       = 32'h4d00005c;
  localparam logic [31:0] ADDR_FRAME_BASE     = 32'h4d000014;
  localparam logic [31:0] ADDR_FRAME_END      = 32'h4d000018;
  localparam logic [31:0] ADDR_CTRL           = 32'h4d000060;
  localparam logic [31:0] ADDR_STATUS         = 32'h4d000064;

  // ------------------------------------------------------------------
  // Field positions and widths
  // ------------------------------------------------------------------
  localparam int SKIP_LSB       = 11;
  localparam int HW_FIELD_W     = 11;
  localparam int OVR_EN_BIT     = 24;
  localparam int OVR_VAL_W      = 24;
  localparam int DITHER_W       = 19;
  localparam int BLUE_MAP_W     = 16;
  localparam int BASE_W         = 21;
  localparam int BANK_LSB       = 21;
  localparam int BANK_W         = 9;
  localparam int IRQ_W          = 2;
  localparam int IRQ_FIFO_BIT   = 0;
  localparam int IRQ_FRAME_BIT  = 1;
  localparam int CTRL_ENABLE    = 0;
  localparam int CTRL_TFT       = 1;

  // ------------------------------------------------------------------
  // Reset values and unmapped read value
  // ------------------------------------------------------------------
  localparam logic [31:0]       RST_WORD = 32'h00000000;
  localparam logic [IRQ_W-1:0]  RST_MASK = 2'h3;
  localparam logic [31:0]       RD_UNMAPPED = 32'h00000000;

endpackage

// ---- core/lcd_addr_counter.sv ----
// Frame buffer half-word address walker for the view port.
// Assumes the fetch engine pulses step_i once per half-word taken.
`timescale 1ns/1ps
module lcd_addr_counter
  import lcd_vs_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  nrst_i,
  // Configuration
  input  wire logic                  run_i,
  input  wire logic [BANK_W-1:0]     bank_i,
  input  wire logic [BASE_W-1:0]     base_i,
  input  wire logic [BASE_W-1:0]     end_i,
  input  wire logic [HW_FIELD_W-1:0] width_i,
  input  wire logic [HW_FIELD_W-1:0] skip_i,
  // Fetch side
  input  wire logic                  step_i,
  output logic [31:0]                addr_o,
  output logic                       frame_done_o
);

  logic [BASE_W-1:0]     addr_q;
  logic [HW_FIELD_W-1:0] col_q;

  // ------------------------------------------------------------------
  // Walk
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_q       <= '0;
      col_q        <= '0;
      frame_done_o <= 1'b0;
    end else begin
      frame_done_o <= 1'b0;
      if (!run_i) begin
        addr_q <= base_i;
        col_q  <= '0;
      end else if (step_i) begin
        if (col_q + 11'h001 >= width_i) begin
          col_q  <= '0;
          addr_q <= addr_q + BASE_W'(1) + BASE_W'(skip_i);
        end else begin
          col_q  <= col_q + 11'h001;
          addr_q <= addr_q + BASE_W'(1);
        end
        // Stop at frame end and restart from the base
        if (addr_q + BASE_W'(1) >= end_i) begin
          addr_q       <= base_i;
          col_q        <= '0;
          frame_done_o <= 1'b1;
        end
      end
    end
  end

  assign addr_o = {1'b0, bank_i, addr_q, 1'b0};

endmodule // lcd_addr_counter

// ---- dv/lcd_fetch_model.sv ----
// Fetch engine and panel stand-in driving the bank's event side.
// Assumes one clock; steps only while the bench holds run_i high.
`timescale 1ns/1ps
module lcd_fetch_model (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // Bench control
  input  wire logic        run_i,
  input  wire logic        slow_i,
  input  wire logic        fifo_req_i,
  // Towards the bank
  output logic             step_o,
  output logic             fifo_o,
  output logic [23:0]      data_o
);
  logic toggle_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      toggle_q <= 1'b0;
      step_o   <= 1'b0;
      fifo_o   <= 1'b0;
      data_o   <= 24'h000000;
    end else begin
      toggle_q <= ~toggle_q;
      step_o   <= run_i && (!slow_i || toggle_q);
      fifo_o   <= fifo_req_i;
      // New pixel each cycle, so a stale copy never matches
      data_o   <= data_o + 24'h010203;
    end
  end
endmodule // lcd_fetch_model

// ---- dv/lcd_vs_regs_properties.sv ----
// Port assertions for the LCD register bank.
// Assumes writes land at the strobe edge; mirrors track them.
`timescale 1ns/1ps
module lcd_vs_regs_properties
  import lcd_vs_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  // Register port
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  // Events and video
  input wire logic        fifo_level_i,
  input wire logic [2:0]  red_code_i,
  input wire logic [2:0]  green_code_i,
  input wire logic [23:0] frame_data_i,
  input wire logic [3:0]  red_shade_o,
  input wire logic [3:0]  green_shade_o,
  input wire logic [23:0] video_data_o,
  input wire logic        frame_sync_irq_o,
  input wire logic        irq_o
);
  logic [31:0] red_q;
  logic [31:0] green_q;
  logic [24:0] ovr_q;
  logic [1:0]  mask_q;
  logic [1:0]  ctrl_q;
  logic [3:0]  red_sel;
  logic [3:0]  green_sel;

  assign red_sel   = red_q[4*red_code_i +: 4];
  assign green_sel = green_q[4*green_code_i +: 4];

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      red_q   <= RST_WORD;
      green_q <= RST_WORD;
      ovr_q   <= 25'h0;
      mask_q  <= RST_MASK;
      ctrl_q  <= 2'h0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_RED_SHADE:   red_q   <= reg_wdata_i;
        ADDR_GREEN_SHADE: green_q <= reg_wdata_i;
        ADDR_OVERRIDE:    ovr_q   <= reg_wdata_i[24:0];
        ADDR_IRQ_MASK:    mask_q  <= reg_wdata_i[1:0];
        ADDR_CTRL:        ctrl_q  <= reg_wdata_i[1:0];
        default:          ;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  property p_red;
    red_shade_o == $past(red_sel);
  endproperty
  a_red: assert property (p_red) else $error("red shade wrong");
  property p_green;
    green_shade_o == $past(green_sel);
  endproperty
  a_green: assert property (p_green) else $error("green shade wrong");
  property p_plain_video;
    (ctrl_q == 2'h0) [*2] |=> video_data_o == $past(frame_data_i);
  endproperty
  a_plain_video: assert property (p_plain_video) else $error("video not delayed data");
  property p_override;
    (ctrl_q == 2'h2 && ovr_q[24] && $stable(ovr_q)) [*3] |=> video_data_o == ovr_q[23:0];
  endproperty
  a_override: assert property (p_override) else $error("override colour not shown");
  property p_masked;
    $past(mask_q) == 2'h3 |-> !irq_o;
  endproperty
  a_masked: assert property (p_masked) else $error("irq while masked");
  property p_fifo;
    fifo_level_i && mask_q == 2'h2 ##1 (mask_q == 2'h2 && !reg_wr_i && !reg_rd_i) [*2]
      |=> irq_o;
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo irq missing");
  property p_frame_mask;
    $rose(frame_sync_irq_o) |-> !$past(mask_q[1]);
  endproperty
  a_frame_mask: assert property (p_frame_mask) else $error("masked frame pending");
  property p_clear;
    reg_wr_i && reg_addr_i == ADDR_IRQ_PEND && reg_wdata_i[1] && mask_q[1]
      |-> ##2 !frame_sync_irq_o;
  endproperty
  a_clear: assert property (p_clear) else $error("pending not cleared");
endmodule // lcd_vs_regs_properties

bind lcd_vs_regs lcd_vs_regs_properties u_props (.clk_sys_i, .nrst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .fifo_level_i, .red_code_i, .green_code_i,
  .frame_data_i, .red_shade_o, .green_shade_o, .video_data_o, .frame_sync_irq_o, .irq_o);

// ---- dv/test_lcd_vs_regs.sv ----
// Directed bench for the LCD register bank.
// Assumes the fetch model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_lcd_vs_regs
  import lcd_vs_pkg::*;
;
  logic        clk_sys_i    = 1'b0;
  logic        nrst_i       = 1'b0;
  logic [31:0] reg_addr_i   = 32'h0;
  logic [31:0] reg_wdata_i  = 32'h0;
  logic        reg_wr_i     = 1'b0;
  logic        reg_rd_i     = 1'b0;
  logic [2:0]  red_code_i   = 3'h0;
  logic [2:0]  green_code_i = 3'h0;
  logic [1:0]  blue_code_i  = 2'h0;
  logic        run          = 1'b0;
  logic        slow         = 1'b0;
  logic        fifo_req     = 1'b0;
  logic        fifo_level_i;
  logic        fetch_step_i;
  logic [23:0] frame_data_i;
  logic [31:0] reg_rdata_o;
  logic [3:0]  red_shade_o;
  logic [3:0]  green_shade_o;
  logic [3:0]  blue_shade_o;
  logic [23:0] video_data_o;
  logic [31:0] fetch_addr_o;
  logic [18:0] dither_o;
  logic        video_output_enable_o;
  logic        frame_sync_irq_o;
  logic        irq_o;
  int          errors       = 0;
  int          cmp_count    = 0;
  int          cyc          = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  lcd_vs_regs uut (.clk_sys_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .fifo_level_i, .fetch_step_i, .red_code_i, .green_code_i, .blue_code_i,
    .frame_data_i, .red_shade_o, .green_shade_o, .blue_shade_o, .video_data_o,
    .fetch_addr_o, .dither_o, .video_output_enable_o, .frame_sync_irq_o, .irq_o);
  lcd_fetch_model u_model (.clk_sys_i, .nrst_i, .run_i(run), .slow_i(slow),
    .fifo_req_i(fifo_req), .step_o(fetch_step_i), .fifo_o(fifo_level_i),
    .data_o(frame_data_i));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #1 chk(n, e, reg_rdata_o);
  endtask

  task automatic wait_chk(input string n, input logic e, input logic g_sel);
    repeat (3) @(posedge clk_sys_i);
    #1 chk(n, {31'h0, e}, {31'h0, g_sel ? frame_sync_irq_o : irq_o});
  endtask

  task automatic fifo_pulse;
    @(posedge clk_sys_i);
    fifo_req <= 1'b1;
    @(posedge clk_sys_i);
    fifo_req <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask

  task automatic t_reset;
    logic [31:0] a[9] = '{ADDR_VIRTUAL_SCREEN, ADDR_RED_SHADE, ADDR_GREEN_SHADE,
      ADDR_BLUE_SHADE, ADDR_DITHER, ADDR_OVERRIDE, ADDR_IRQ_PEND, ADDR_IRQ_SRC, ADDR_IRQ_MASK};
    foreach (a[i]) rd(a[i], (i == 8) ? {30'h0, RST_MASK} : RST_WORD, "reset");
    $display("test reset done");
  endtask

  task automatic t_shade;
    wr(ADDR_RED_SHADE, 32'hfedcba98);
    wr(ADDR_GREEN_SHADE, 32'h13579bdf);
    wr(ADDR_BLUE_SHADE, 32'hffff4c2a);
    rd(ADDR_BLUE_SHADE, 32'h00004c2a, "blue_map");
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_sys_i);
      red_code_i   <= 3'(c);
      green_code_i <= 3'(7 - c);
      blue_code_i  <= 2'(c);
      @(posedge clk_sys_i);
      #1 chk("red", (32'hfedcba98 >> (4 * c)) & 32'hf, {28'h0, red_shade_o});
      chk("green", (32'h13579bdf >> (4 * (7 - c))) & 32'hf, {28'h0, green_shade_o});
      chk("blue", (32'h4c2a >> (4 * (c % 4))) & 32'hf, {28'h0, blue_shade_o});
    end
    $display("test shade done");
  endtask

  task automatic t_misc;
    wr(ADDR_DITHER, 32'h00012210);
    rd(ADDR_DITHER, 32'h00012210, "dither_reg");
    chk("dither_out", 32'h00012210, {13'h0, dither_o});
    // Unmapped word, clear of the reserved test window
    wr(32'h4d000068, 32'hffffffff);
    rd(32'h4d000068, RD_UNMAPPED, "unmapped");
    $display("test misc done");
  endtask

  task automatic t_walk;
    logic [31:0] seen[$];
    logic [20:0] off[6] = '{21'd0, 21'd1, 21'd2, 21'd5, 21'd6, 21'd7};
    int n = 0;
    wr(ADDR_FRAME_BASE, {2'b00, 9'h031, 21'h080000});
    wr(ADDR_FRAME_END, 32'h00080008);
    // Width and skip only while output is off
    wr(ADDR_VIRTUAL_SCREEN, 32'h00001003);
    rd(ADDR_VIRTUAL_SCREEN, 32'h00001003, "view_reg");
    wr(ADDR_CTRL, 32'h1);
    @(posedge clk_sys_i);
    run  <= 1'b1;
    slow <= 1'b1;
    #1 chk("out_enable", 32'h1, {31'h0, video_output_enable_o});
    @(negedge clk_sys_i);
    seen.push_back(fetch_addr_o);
    while (seen.size() < 7 && n < 80) begin
      @(negedge clk_sys_i);
      n++;
      if (fetch_addr_o !== seen[$]) seen.push_back(fetch_addr_o);
    end
    @(posedge clk_sys_i);
    run <= 1'b0;
    foreach (off[i]) chk("addr", {1'b0, 9'h031, 21'h080000 + off[i], 1'b0}, seen[i]);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_IRQ_PEND, 32'h0, "pend_masked");
    wr(ADDR_IRQ_MASK, 32'h1);
    wait_chk("irq_frame", 1'b1, 1'b0);
    chk("frame_irq", 32'h1, {31'h0, frame_sync_irq_o});
    wr(ADDR_IRQ_SRC, 32'h2);
    rd(ADDR_IRQ_SRC, 32'h0, "src_w1c");
    wr(ADDR_IRQ_PEND, 32'h2);
    wait_chk("irq_w1c", 1'b0, 1'b0);
    $display("test walk done");
  endtask

  task automatic t_fifo;
    wr(ADDR_IRQ_MASK, 32'h2);
    fifo_pulse();
    #1 chk("irq_fifo", 32'h1, {31'h0, irq_o});
    rd(ADDR_IRQ_SRC, 32'h1, "src_fifo");
    rd(ADDR_IRQ_PEND, 32'h1, "pend_fifo");
    wait_chk("irq_read_clr", 1'b0, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h3);
    fifo_pulse();
    #1 chk("irq_masked", 32'h0, {31'h0, irq_o});
    rd(ADDR_IRQ_SRC, 32'h1, "src_masked");
    rd(ADDR_IRQ_PEND, 32'h0, "pend_masked");
    wr(ADDR_IRQ_PEND, 32'h3);
    $display("test fifo done");
  endtask

  task automatic t_override;
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_OVERRIDE, 32'h01a1b2c3);
    repeat (3) @(posedge clk_sys_i);
    #1 chk("override", 32'h00a1b2c3, {8'h0, video_data_o});
    rd(ADDR_OVERRIDE, 32'h01a1b2c3, "override_reg");
    wr(ADDR_CTRL, 32'h0);
    $display("test override done");
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_reset();
    t_shade();
    t_misc();
    t_walk();
    t_fifo();
    t_override();
    stop_test();
  end
endmodule // test_lcd_vs_regs
